// *** design/timer_pkg.sv ***
// Shared constants and types for the sixteen-bit timer/counter
package timer_pkg;

   // ------------------------------------------------------------------
   // Bus widths
   // ------------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [9:0] IDX_FLAGS   = 10'h00c;
   localparam logic [9:0] IDX_CNT_LO  = 10'h00e;
   localparam logic [9:0] IDX_CNT_HI  = 10'h00f;
   localparam logic [9:0] IDX_CTRL    = 10'h010;
   localparam logic [9:0] IDX_ENABLES = 10'h08c;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CTRL_ON_BIT     = 0;
   localparam int CTRL_CS_BIT     = 1;
   localparam int CTRL_SYNC_N_BIT = 2;
   localparam int CTRL_OSC_EN_BIT = 3;
   localparam int CTRL_PS_LO_BIT  = 4;
   localparam int CTRL_PS_HI_BIT  = 5;
   localparam int ROLLOVER_BIT    = 0;

   // ------------------------------------------------------------------
   // Reset values and masks
   // ------------------------------------------------------------------
   localparam logic [7:0]  CTRL_RESET  = 8'h00;
   localparam logic [7:0]  CTRL_MASK   = 8'h3f;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX   = 16'hffff;

   // ------------------------------------------------------------------
   // Timing counts
   // ------------------------------------------------------------------
   localparam int         FOSC_DIV        = 4;
   localparam logic [1:0] FOSC_LAST       = 2'(FOSC_DIV - 1);
   localparam int         PRESCALE_STAGES = 3;

   // ------------------------------------------------------------------
   // Bus slave states
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      APB_IDLE = 2'b01,
      APB_ACK  = 2'b10
   } apb_state_type;

endpackage : timer_pkg

// *** design/prescale_if.sv ***
// Link between the counter core and its ripple prescaler
`timescale 1ns/100ps
interface prescale_if;
   logic       tick_in;                 // Rising edge of the selected count input
   logic       clear;                   // Hold all stages at zero
   logic [1:0] ratio_sel;               // 0..3 selects divide by 1, 2, 4, 8
   logic       tick_out;                // Divided tick

   modport core (input tick_in, input clear, input ratio_sel, output tick_out);
   modport user (output tick_in, output clear, output ratio_sel, input tick_out);
endinterface : prescale_if

// *** design/ripple_prescaler.sv ***
// Ripple-style prescaler: each stage toggles when the one below falls
`timescale 1ns/100ps
module ripple_prescaler #(
   parameter int STAGES = timer_pkg::PRESCALE_STAGES
) (
   // Clock and reset
   input wire logic   pclk,
   input wire logic   presetn,
   // Link to the counter core
   prescale_if.core   ps
);
   import timer_pkg::*;

   logic [STAGES-1:0] stage_q;
   logic [STAGES:0]   carry;

   // Carry chain: a stage passes on the tick when it falls from one to zero
   assign carry[0] = ps.tick_in;

   genvar i;
   generate
      for (i = 0; i < STAGES; i++) begin : g_stage
         assign carry[i+1] = carry[i] & stage_q[i];
         // One toggle stage of the ripple chain
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stage_q[i] <= 1'b0;
            end else if (ps.clear) begin
               stage_q[i] <= 1'b0;
            end else if (carry[i]) begin
               stage_q[i] <= ~stage_q[i];
            end
         end
      end
   endgenerate

   // Pick the tap for the requested ratio
   assign ps.tick_out = carry[ps.ratio_sel] & ~ps.clear;

endmodule : ripple_prescaler

// *** design/sixteen_bit_timer_counter.sv ***
// Sixteen-bit timer/counter with prescaler, rollover interrupt and APB slave
//
// Notes on behaviour
// [RQ1] Clock-source bit clear: count the internal clock, oscillator over four.
// [RQ2] In timer mode the sync control bit has no effect.
// [RQ3] External counting increments on rising edges of the source.
// [RQ4] After enable in counter mode, wait for a falling edge first.
// [RQ5] Clock-source bit set: count oscillator pin or external pin per enable bit.
// [RQ6] Sync bit clear: resynchronise after the prescaler.
// [RQ7] Prescaler is a ripple chain driven by the selected count input.
// [RQ8] Synchronised counter mode in sleep: counter holds, prescaler keeps going.
// [RQ9] Control layout: ps 5:4, osc 3, sync 2, source 1, on 0; 7:6 zero.
// [RQ10] Control clears on power-on reset only.
// [RQ11] Count readable and writable as low byte and high byte.
// [RQ12] Rollover flag at bit 0 of flags, enable at bit 0 of enables.
// [RQ13] Rollover from all ones to zero sets a sticky flag.
// [RQ14] Prescale field divides by 1, 2, 4, 8; counter-on clear stops counting.
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module sixteen_bit_timer_counter (
   // Clock and reset
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   // APB slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [timer_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [timer_pkg::DATA_W-1:0]   pwdata,
   output logic      [timer_pkg::DATA_W-1:0]   prdata,
   output logic                                pready,
   output logic                                pslverr,
   // Count inputs and power state
   input  wire logic                           ext_count_pin,
   input  wire logic                           osc_input_pin,
   input  wire logic                           sleep_mode,
   // Interrupt
   output logic                                irq
);
   import timer_pkg::*;

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   apb_state_type        apb_state_q;
   logic [DATA_W-1:0]    prdata_q;
   logic                 pslverr_q;
   logic                 irq_q;
   logic [7:0]           ctrl_q;
   logic [15:0]          count_q;
   logic                 flag_q;
   logic                 enable_q;
   logic [1:0]           fosc_div_q;
   logic                 sel_prev_q;
   logic                 armed_q;
   logic                 sync_tick_q;
   logic                 counter_on;
   logic                 clock_source_select;
   logic                 sync_disable_n;
   logic                 osc_input_enable;
   logic [1:0]           prescale_sel;
   logic                 fosc_tick;
   logic                 sel_pin;
   logic                 pin_rise;
   logic                 pin_fall;
   logic                 inc;
   logic                 rollover;
   logic                 access;
   logic                 wr_en;
   logic [9:0]           idx;
   logic                 mapped;
   logic [7:0]           rd_byte;

   prescale_if ps_link ();

   // ------------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------------
   assign counter_on          = ctrl_q[CTRL_ON_BIT];
   assign clock_source_select = ctrl_q[CTRL_CS_BIT];
   assign sync_disable_n      = ctrl_q[CTRL_SYNC_N_BIT];
   assign osc_input_enable    = ctrl_q[CTRL_OSC_EN_BIT];
   assign prescale_sel        = {ctrl_q[CTRL_PS_HI_BIT], ctrl_q[CTRL_PS_LO_BIT]};

   // ------------------------------------------------------------------
   // APB slave: one wait state, answer registered
   // ------------------------------------------------------------------
   assign idx    = paddr[11:2];
   assign access = psel & penable & (apb_state_q == APB_IDLE);
   assign wr_en  = psel & penable & pready & pwrite & mapped;
   assign mapped = (idx == IDX_FLAGS) | (idx == IDX_CNT_LO) | (idx == IDX_CNT_HI)
                 | (idx == IDX_CTRL) | (idx == IDX_ENABLES);

   // Read multiplexer; unused bits read as zero
   always_comb begin
      rd_byte = 8'h00;
      case (idx)
         IDX_FLAGS:   rd_byte = {7'h00, flag_q};             // RQ12
         IDX_ENABLES: rd_byte = {7'h00, enable_q};           // RQ12
         IDX_CNT_LO:  rd_byte = count_q[7:0];                // RQ11
         IDX_CNT_HI:  rd_byte = count_q[15:8];               // RQ11
         IDX_CTRL:    rd_byte = ctrl_q & CTRL_MASK;          // RQ9
         default:     rd_byte = 8'h00;
      endcase
   end

   // Handshake state and registered answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_state_q <= APB_IDLE;
         pready      <= 1'b0;
         prdata_q    <= '0;
         pslverr_q   <= 1'b0;
      end else begin
         case (apb_state_q)
            APB_IDLE: begin
               pready    <= 1'b0;
               pslverr_q <= 1'b0;
               if (access) begin
                  apb_state_q <= APB_ACK;
                  pready      <= 1'b1;
                  pslverr_q   <= ~mapped;
                  prdata_q    <= pwrite ? '0 : {24'h000000, rd_byte};
               end
            end
            APB_ACK: begin
               apb_state_q <= APB_IDLE;
               pready      <= 1'b0;
               pslverr_q   <= 1'b0;
            end
            default: begin
               apb_state_q <= APB_IDLE;
               pready      <= 1'b0;
            end
         endcase
      end
   end
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;

   // ------------------------------------------------------------------
   // Software-written registers
   // ------------------------------------------------------------------
   // Control register, cleared only by the power-on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RESET;                                 // RQ10
      end else if (wr_en && idx == IDX_CTRL) begin
         ctrl_q <= pwdata[7:0] & CTRL_MASK;                    // RQ9
      end
   end

   // Rollover interrupt enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q <= 1'b0;
      end else if (wr_en && idx == IDX_ENABLES) begin
         enable_q <= pwdata[ROLLOVER_BIT];                     // RQ12
      end
   end

   // ------------------------------------------------------------------
   // Count sources
   // ------------------------------------------------------------------
   // Internal clock divider: one tick every four system clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fosc_div_q <= 2'b00;
      end else begin
         fosc_div_q <= (fosc_div_q == FOSC_LAST) ? 2'b00 : fosc_div_q + 2'b01;
      end
   end
   assign fosc_tick = (fosc_div_q == FOSC_LAST);               // RQ1

   // Selected external input and its edges
   assign sel_pin  = osc_input_enable ? osc_input_pin : ext_count_pin;  // RQ5
   assign pin_rise = sel_pin & ~sel_prev_q;                    // RQ3
   assign pin_fall = ~sel_pin & sel_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_prev_q <= 1'b0;
      end else begin
         sel_prev_q <= sel_pin;
      end
   end

   // Arm only after a falling edge once enabled in counter mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_q <= 1'b0;
      end else if (!(counter_on && clock_source_select)) begin
         armed_q <= 1'b0;                                      // RQ4
      end else if (pin_fall) begin
         armed_q <= 1'b1;                                      // RQ4
      end
   end

   // ------------------------------------------------------------------
   // Prescaler
   // ------------------------------------------------------------------
   assign ps_link.tick_in   = clock_source_select ? (pin_rise & armed_q)  // RQ7
                                                  : fosc_tick;            // RQ1
   assign ps_link.clear     = ~counter_on;                     // RQ14
   assign ps_link.ratio_sel = prescale_sel;                    // RQ14

   ripple_prescaler #(
      .STAGES (PRESCALE_STAGES)
   ) u_prescaler (
      .pclk    (pclk),
      .presetn (presetn),
      .ps      (ps_link.core)
   );

   // Synchroniser stage behind the prescaler
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_tick_q <= 1'b0;
      end else begin
         sync_tick_q <= ps_link.tick_out;                      // RQ6
      end
   end

   // Increment: timer mode ignores sync; sync path is off in sleep
   always_comb begin
      if (!counter_on) begin
         inc = 1'b0;                                           // RQ14
      end else if (!clock_source_select) begin
         inc = ps_link.tick_out;                               // RQ2
      end else if (sync_disable_n) begin
         inc = ps_link.tick_out;
      end else begin
         inc = sync_tick_q & ~sleep_mode;                      // RQ8
      end
   end

   // ------------------------------------------------------------------
   // Count and rollover flag
   // ------------------------------------------------------------------
   assign rollover = inc & (count_q == COUNT_MAX);             // RQ13

   // Count: a byte write wins over an increment in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= COUNT_RESET;
      end else if (wr_en && idx == IDX_CNT_LO) begin
         count_q[7:0] <= pwdata[7:0];                          // RQ11
      end else if (wr_en && idx == IDX_CNT_HI) begin
         count_q[15:8] <= pwdata[7:0];                         // RQ11
      end else if (inc) begin
         count_q <= count_q + 16'h0001;
      end
   end

   // Sticky flag: write one to clear, a new rollover wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (rollover) begin
         flag_q <= 1'b1;                                       // RQ13
      end else if (wr_en && idx == IDX_FLAGS && pwdata[ROLLOVER_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   // Level interrupt while an enabled flag is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= flag_q & enable_q;                           // RQ12
      end
   end
   assign irq = irq_q;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_TIMER_SOURCE: assert property (inc && !clock_source_select |-> fosc_tick) // RQ1
      else $error("timer mode increment off the divided clock");
   AST_TIMER_SYNC_IGNORED: assert property (                                      // RQ2
      counter_on && !clock_source_select && prescale_sel == 2'b00 && fosc_tick
      |-> inc)
      else $error("timer mode missed a tick");
   AST_ASYNC_RISING: assert property (                                            // RQ3
      inc && clock_source_select && sync_disable_n |-> pin_rise)
      else $error("async count without rising edge");
   AST_ARMED_FIRST: assert property (inc && clock_source_select |-> armed_q)     // RQ4
      else $error("counted before a falling edge");
   AST_SYNC_DELAY: assert property (                                              // RQ6
      counter_on && clock_source_select && !sync_disable_n && ps_link.tick_out
      ##1 (counter_on && clock_source_select && !sync_disable_n && !sleep_mode)
      |-> inc)
      else $error("sync path did not pass the tick");
   AST_SLEEP_HOLD: assert property (                                              // RQ8
      sleep_mode && clock_source_select && !sync_disable_n |-> !inc)
      else $error("counter moved in sleep");
   AST_CTRL_READ: assert property (                                               // RQ9
      access && !pwrite && idx == IDX_CTRL |=> prdata[31:6] == 26'h0 && pready)
      else $error("control read upper bits not zero");
   AST_IRQ_LEVEL: assert property (irq == $past(flag_q & enable_q, 1))            // RQ12
      else $error("irq does not follow flag and enable");
   AST_ROLLOVER_FLAG: assert property (                                           // RQ13
      rollover && !(wr_en && (idx == IDX_CNT_LO || idx == IDX_CNT_HI))
      |=> flag_q && count_q == COUNT_RESET)
      else $error("rollover did not set flag");
   AST_OFF_STOPS: assert property (!counter_on |-> !inc)                          // RQ14
      else $error("counted while off");

   COV_ROLLOVER: cover property (rollover ##[1:4] irq);
   COV_SYNC_COUNT: cover property (inc && clock_source_select && !sync_disable_n);
   COV_DIV8: cover property (inc && prescale_sel == 2'b11);

endmodule : sixteen_bit_timer_counter

// *** verification/count_source.sv ***
// Behavioural count-clock source driving the external and oscillator count pins
`timescale 1ns/100ps
module count_source (
   // Clock
   input  wire logic pclk,
   // Count pins
   output logic      ext_count_pin,
   output logic      osc_input_pin
);
   // ------------------------------------------------------------------
   // Idle level
   // ------------------------------------------------------------------
   // Both lines stand still and low between bursts
   initial begin
      ext_count_pin = 1'b0;
      osc_input_pin = 1'b0;
   end

   // ------------------------------------------------------------------
   // Burst generator
   // ------------------------------------------------------------------
   // Emit n pulses on one pin; each level holds for half cycles, then rest
   task automatic burst(input int n, input int half, input bit on_osc);
      for (int i = 0; i < n; i++) begin
         repeat (half) @(posedge pclk);
         if (on_osc) osc_input_pin <= 1'b1;
         else ext_count_pin <= 1'b1;
         repeat (half) @(posedge pclk);
         if (on_osc) osc_input_pin <= 1'b0;
         else ext_count_pin <= 1'b0;
      end
      repeat (4) @(posedge pclk);
   endtask : burst
endmodule : count_source

// *** verification/sixteen_bit_timer_counter_tb.sv ***
// Self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module sixteen_bit_timer_counter_tb;
   import timer_pkg::*;
   // ------------------------------------------------------------------
   // Signals and model state
   // ------------------------------------------------------------------
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic              ext_count_pin;
   logic              osc_input_pin;
   logic              sleep_mode;
   logic              irq;
   logic [31:0]       rd;
   logic              err;
   logic [15:0]       v;
   logic [15:0]       start;
   logic [7:0]        ctrl;
   logic [7:0]        a;
   bit                s;
   int                miscompares;
   int                checked;
   int                cyc;
   int                last_len;
   int                m_cnt;
   int                m_pre;

   // Design and count source
   sixteen_bit_timer_counter sixteen_bit_timer_counter_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
      .osc_input_pin(osc_input_pin), .sleep_mode(sleep_mode), .irq(irq));
   count_source count_source_inst (.pclk(pclk), .ext_count_pin(ext_count_pin),
      .osc_input_pin(osc_input_pin));

   // 100 MHz clock
   always #5 pclk = ~pclk;

   // Cycle ceiling cuts a hang short
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         test_done();
      end
   end

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   // Verdict and end of run
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done

   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input bit wr, input logic [9:0] idx, input logic [7:0] wd);
      int n;
      n = 2;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle budget here: only the bench ceiling may end a hung transfer
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd       = prdata;
      err      = pslverr;
      last_len = n;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Read one register and compare its byte
   task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      `CHK(rd, {24'h000000, exp})
   endtask : rdchk

   // Read the full count as two bytes
   task automatic rdcount(output logic [15:0] c);
      apb(1'b0, IDX_CNT_LO, 8'h00);
      c[7:0] = rd[7:0];
      apb(1'b0, IDX_CNT_HI, 8'h00);
      c[15:8] = rd[7:0];
   endtask : rdcount

   // Burst on a pin, then step the model by each counted rising edge
   task automatic pulses(input int n, input bit skip, input int div, input bit frz, input bit p);
      count_source_inst.burst(n, 1 + $urandom % 3, p);
      for (int i = (skip ? 1 : 0); i < n; i++) begin
         m_pre++;
         if (m_pre == div) begin
            m_pre = 0;
            if (!frz) m_cnt = (m_cnt + 1) % 65536;
         end
      end
   endtask : pulses

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      pclk        = 1'b0;
      presetn     = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = '0;
      pwdata      = '0;
      sleep_mode  = 1'b0;
      miscompares = 0;
      checked     = 0;
      cyc         = 0;
      void'($urandom(26));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, layout, unmapped access
      rdchk(IDX_CTRL, 8'h00);
      rdchk(IDX_CNT_LO, 8'h00);
      rdchk(IDX_CNT_HI, 8'h00);
      rdchk(IDX_FLAGS, 8'h00);
      rdchk(IDX_ENABLES, 8'h00);
      apb(1'b1, IDX_CTRL, 8'hfe);
      rdchk(IDX_CTRL, 8'h3e);
      apb(1'b1, IDX_ENABLES, 8'hff);
      rdchk(IDX_ENABLES, 8'h01);
      a = 8'($urandom);
      apb(1'b1, IDX_CNT_HI, a);
      rdchk(IDX_CNT_HI, a);
      apb(1'b0, 10'h011, 8'h00);
      `CHK({err, rd}, {1'b1, 32'h0})
      $display("test registers done");
      // Timer rate for every prescale and both sync settings
      for (int cfg = 0; cfg < 8; cfg++) begin
         apb(1'b1, IDX_CTRL, 8'h00);
         apb(1'b1, IDX_CTRL, {2'b00, 2'(cfg), 1'b0, cfg[2], 2'b01});
         apb(1'b0, IDX_CNT_LO, 8'h00);
         a = rd[7:0];
         repeat (128 - last_len) @(posedge pclk);
         apb(1'b0, IDX_CNT_LO, 8'h00);
         `CHK(8'(rd[7:0] - a), 8'(32 >> cfg[1:0]))
      end
      $display("test timer done");
      // Counter mode over every pin, sync and prescale choice
      for (int cfg = 0; cfg < 16; cfg++) begin
         ctrl  = {2'b00, 2'(cfg), cfg[3], cfg[2], 2'b11};
         start = 16'($urandom);
         s     = !cfg[2] || 1'($urandom);  // Synchronised runs always see sleep
         apb(1'b1, IDX_CTRL, 8'h00);
         apb(1'b1, IDX_CNT_LO, start[7:0]);
         apb(1'b1, IDX_CNT_HI, start[15:8]);
         apb(1'b1, IDX_CTRL, ctrl);
         m_cnt = int'(start);
         m_pre = 0;
         count_source_inst.burst(3, 1, !cfg[3]);
         sleep_mode <= s;
         pulses(3 + $urandom % 12, 1'b1, 1 << cfg[1:0], s && !cfg[2], cfg[3]);
         sleep_mode <= 1'b0;
         pulses(2 + $urandom % 12, 1'b0, 1 << cfg[1:0], 1'b0, cfg[3]);
         apb(1'b1, IDX_CTRL, ctrl & 8'hfe);
         count_source_inst.burst(3, 1, cfg[3]);
         rdcount(v);
         `CHK(v, 16'(m_cnt))
      end
      $display("test counter done");
      // Rollover flag, mask and write-one clear
      apb(1'b1, IDX_CTRL, 8'h00);
      apb(1'b1, IDX_FLAGS, 8'h01);
      apb(1'b1, IDX_CNT_LO, 8'hff);
      apb(1'b1, IDX_CNT_HI, 8'hff);
      apb(1'b1, IDX_ENABLES, 8'h01);
      apb(1'b1, IDX_CTRL, 8'h07);
      count_source_inst.burst(2, 2, 1'b0);
      `CHK(irq, 1'b1)
      rdchk(IDX_FLAGS, 8'h01);
      rdcount(v);
      `CHK(v, 16'h0000)
      apb(1'b1, IDX_ENABLES, 8'h00);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      apb(1'b1, IDX_ENABLES, 8'h01);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b1)
      apb(1'b1, IDX_FLAGS, 8'h01);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      rdchk(IDX_FLAGS, 8'h00);
      $display("test rollover done");
      // Second reset in mid-run clears control
      apb(1'b1, IDX_CTRL, 8'h35);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(IDX_CTRL, 8'h00);
      $display("test reset done");
      test_done();
   end
endmodule : sixteen_bit_timer_counter_tb
